// >>> logic/mfiw_top.sv
// grouped interrupt flags, vector request and wake-up for low-voltage and timer sources
// Summary of operation
// - low-voltage flag sets on low supply or a high level on the synchronised detector pin
// - low-voltage vector needs global, source and group enable, stack not full
// - servicing low-voltage clears global enable and group flag, not source flag
// - each timer has comparator A and P flags with own enables
// - timer vector needs global, timer and group enable, stack not full
// - servicing timer clears global enable and group flag only
// - while sleepMode is high, any flag rising edge wakes, enables ignored
// - flag already high before sleep gives no wake-up
// - a set flag stays set until serviced or cleared by software
// - on entry only the program counter is pushed
// - interrupt return sets global enable, plain return leaves it clear
// - group flag sets when any member source flag becomes set
`timescale 1ns/1ps
`default_nettype none
`include "mfiw_cfg.svh"
module mfiw_top
   import mfiw_pkg::*;
#(
   parameter int NUM_TM = `MFIW_NUM_TM
)
(
   input wire logic mclk,
   input wire logic rstn,
   input wire logic lowSupply,
   input wire logic voltage_detect_input_pin,
   input wire logic [NUM_TM-1:0] tmMatchA,
   input wire logic [NUM_TM-1:0] tmMatchP,
   input wire logic low_voltage_irq_enable,
   input wire logic [NUM_TM-1:0] tmEnableA,
   input wire logic [NUM_TM-1:0] tmEnableP,
   input wire logic [`MFIW_NUM_GRP-1:0] grouped_irq_enable,
   input wire logic [2*NUM_TM:0] srcFlagSet,
   input wire logic [2*NUM_TM:0] srcFlagClr,
   input wire logic globalEnableSet,
   input wire logic globalEnableClr,
   input wire logic sleepMode,
   input wire mfiw_cpu_t cpu,
   output logic low_voltage_request_flag,
   output logic [NUM_TM-1:0] tmFlagA,
   output logic [NUM_TM-1:0] tmFlagP,
   output logic [`MFIW_NUM_GRP-1:0] grouped_irq_request_flag,
   output logic global_irq_enable,
   output var mfiw_vec_t vec,
   output logic wake
);
   localparam int NSRC = 2 * NUM_TM + 1;

   logic pinMeta;
   logic pinSync;
   logic [NSRC-1:0] srcHw;
   logic [NSRC-1:0] srcEn;
   logic [NSRC-1:0] srcFlag;
   logic [NSRC-1:0] srcRise;
   logic [`MFIW_NUM_GRP-1:0] grpRise;
   logic [`MFIW_NUM_GRP-1:0] grpHw;
   logic [`MFIW_NUM_GRP-1:0] grpSvc;
   logic [`MFIW_NUM_GRP-1:0] grpCond;
   logic pendLv;
   logic pendTm;
   logic service;
   mfiw_state_t state;
   mfiw_state_t next_state;
   mfiw_vec_t next_vec;
   logic next_ge;
   logic next_wake;
   logic next_pinMeta;
   logic next_pinSync;

   // detector pin synchroniser
   always_comb
   begin
      next_pinMeta = voltage_detect_input_pin;
      next_pinSync = pinMeta;
   end

   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         pinMeta <= 1'b0;
         pinSync <= 1'b0;
      end
      else
      begin
         pinMeta <= next_pinMeta;
         pinSync <= next_pinSync;
      end
   end

   // source mapping: 0 low voltage, then A/P per timer
   always_comb
   begin
      srcHw = '0;
      srcEn = '0;
      srcHw[`MFIW_SRC_LV] = lowSupply | pinSync;
      srcEn[`MFIW_SRC_LV] = low_voltage_irq_enable;
      for (int i = 0; i < NUM_TM; i++)
      begin
         srcHw[1 + 2 * i] = tmMatchA[i];
         srcHw[2 + 2 * i] = tmMatchP[i];
         srcEn[1 + 2 * i] = tmEnableA[i];
         srcEn[2 + 2 * i] = tmEnableP[i];
      end
   end

   genvar g;
   generate
      for (g = 0; g < NSRC; g++)
      begin : gSrc
         mfiw_flag uFlag
         (
            .mclk(mclk),
            .rstn(rstn),
            .hwSet(srcHw[g]),
            .swSet(srcFlagSet[g]),
            .swClr(srcFlagClr[g]),
            .svcClr(1'b0),
            .flag(srcFlag[g]),
            .rise(srcRise[g])
         );
      end
      for (g = 0; g < NUM_TM; g++)
      begin : gTm
         assign tmFlagA[g] = srcFlag[1 + 2 * g];
         assign tmFlagP[g] = srcFlag[2 + 2 * g];
      end
   endgenerate

   assign low_voltage_request_flag = srcFlag[`MFIW_SRC_LV];

   // group flags follow member flags becoming set
   always_comb
   begin
      service = (state == ST_PEND) && cpu.ack;
      grpHw[`MFIW_GRP_LV] = srcRise[`MFIW_SRC_LV];
      grpHw[`MFIW_GRP_TM] = |srcRise[NSRC-1:1];
      grpSvc = '0;
      grpSvc[vec.grp] = service;
   end

   generate
      for (g = 0; g < `MFIW_NUM_GRP; g++)
      begin : gGrp
         mfiw_flag uGrp
         (
            .mclk(mclk),
            .rstn(rstn),
            .hwSet(grpHw[g]),
            .swSet(1'b0),
            .swClr(1'b0),
            .svcClr(grpSvc[g]),
            .flag(grouped_irq_request_flag[g]),
            .rise(grpRise[g])
         );
      end
   endgenerate

   // vector request and global enable
   always_comb
   begin
      pendLv = srcFlag[`MFIW_SRC_LV] & srcEn[`MFIW_SRC_LV];
      pendTm = |(srcFlag[NSRC-1:1] & srcEn[NSRC-1:1]);
      grpCond[`MFIW_GRP_LV] = global_irq_enable & grouped_irq_enable[`MFIW_GRP_LV]
         & grouped_irq_request_flag[`MFIW_GRP_LV] & pendLv & ~cpu.stackFull;
      grpCond[`MFIW_GRP_TM] = global_irq_enable & grouped_irq_enable[`MFIW_GRP_TM]
         & grouped_irq_request_flag[`MFIW_GRP_TM] & pendTm & ~cpu.stackFull;
      next_state = state;
      next_vec = vec;
      next_vec.push = 1'b0;
      unique case (state)
         ST_IDLE:
         begin
            if (|grpCond)
            begin
               next_state = ST_PEND;
               next_vec.req = 1'b1;
               next_vec.grp = ~grpCond[`MFIW_GRP_LV];
            end
         end
         ST_PEND:
         begin
            if (cpu.ack)
            begin
               next_state = ST_IDLE;
               next_vec.req = 1'b0;
               next_vec.push = 1'b1;
            end
            else if (!grpCond[vec.grp])
            begin
               next_state = ST_IDLE;
               next_vec.req = 1'b0;
            end
         end
      endcase
      next_ge = global_irq_enable;
      if (service)
         next_ge = 1'b0;
      else if (cpu.return_from_interrupt_instr || globalEnableSet)
         next_ge = 1'b1;
      else if (globalEnableClr)
         next_ge = 1'b0;
      next_wake = sleepMode & (|srcRise | |grpRise);
   end

   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         state <= ST_IDLE;
         vec <= '0;
         global_irq_enable <= `MFIW_GE_RST;
         wake <= 1'b0;
      end
      else
      begin
         state <= next_state;
         vec <= next_vec;
         global_irq_enable <= next_ge;
         wake <= next_wake;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   sequence svcSeq;
      state == ST_PEND && cpu.ack;
   endsequence

   sequence pushSeq;
      vec.push && !vec.req && !global_irq_enable;
   endsequence

   lv_vector_a: assert property (state == ST_IDLE && grpCond == 2'b01
      |=> vec.req && !vec.grp)
      else $error("low-voltage vector missing");
   tm_gate_a: assert property (vec.req && $rose(vec.req) |-> $past(global_irq_enable)
      && !$past(cpu.stackFull))
      else $error("vector without enables");
   svc_clear_a: assert property (svcSeq |=> pushSeq)
      else $error("service did not clear enable");
   src_kept_a: assert property (state == ST_PEND && cpu.ack && !srcFlagClr[0]
      && srcFlag[0] |=> srcFlag[0])
      else $error("source flag cleared by service");
   return_from_interrupt_instr_sets_a: assert property (cpu.return_from_interrupt_instr && !service |=> global_irq_enable)
      else $error("return did not restore enable");
   ret_keeps_a: assert property (cpu.ret && !cpu.return_from_interrupt_instr && !globalEnableSet
      && !global_irq_enable |=> !global_irq_enable)
      else $error("plain return changed enable");
   grp_set_a: assert property (|srcRise[NSRC-1:1] |=> grouped_irq_request_flag[1])
      else $error("group flag not set");
   wake_edge_a: assert property (sleepMode && $rose(srcFlag[0]) |=> wake)
      else $error("no wake on flag rise");
   no_wake_a: assert property (!sleepMode |=> !wake)
      else $error("wake outside sleep");
   lv_set_a: assert property (lowSupply |=> low_voltage_request_flag)
      else $error("low supply not flagged");
endmodule : mfiw_top
`default_nettype wire

// >>> logic/mfiw_cfg.svh
// constants for the grouped interrupt and wake-up block
`ifndef MFIW_CFG_SVH
`define MFIW_CFG_SVH
`define MFIW_NUM_TM 2
`define MFIW_NUM_GRP 2
`define MFIW_GRP_LV 0
`define MFIW_GRP_TM 1
`define MFIW_SRC_LV 0
`define MFIW_GE_RST 1'b0
`define MFIW_FLAG_RST 1'b0
`endif

// >>> logic/mfiw_pkg.sv
// types for the grouped interrupt and wake-up block
`default_nettype none
package mfiw_pkg;
   typedef enum logic [0:0] {ST_IDLE, ST_PEND} mfiw_state_t;
   typedef struct packed {
      logic req;
      logic grp;
      logic push;
   } mfiw_vec_t;
   typedef struct packed {
      logic ack;
      logic return_from_interrupt_instr;
      logic ret;
      logic stackFull;
   } mfiw_cpu_t;
endpackage : mfiw_pkg
`default_nettype wire

// >>> logic/mfiw_flag.sv
// one request flag with set, clear and rising-edge output
`timescale 1ns/1ps
`default_nettype none
`include "mfiw_cfg.svh"
module mfiw_flag
(
   input wire logic mclk,
   input wire logic rstn,
   input wire logic hwSet,
   input wire logic swSet,
   input wire logic swClr,
   input wire logic svcClr,
   output logic flag,
   output logic rise
);
   logic next_flag;
   logic next_rise;

   always_comb
   begin
      // set beats any clear in the same cycle
      next_flag = hwSet | swSet | (flag & ~swClr & ~svcClr);
      next_rise = next_flag & ~flag;
   end

   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         flag <= `MFIW_FLAG_RST;
         rise <= 1'b0;
      end
      else
      begin
         flag <= next_flag;
         rise <= next_rise;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   set_wins_a: assert property (hwSet |=> flag)
      else $error("hardware set lost");
   flag_holds_a: assert property (flag && !swClr && !svcClr |=> flag)
      else $error("flag dropped without clear");
   rise_once_a: assert property ($rose(flag) |-> rise)
      else $error("no rise pulse on flag set");
endmodule : mfiw_flag
`default_nettype wire

// >>> testbench/mfiw_cpu_model.sv
// cpu core stand-in that takes vector requests and issues returns
`timescale 1ns/1ps
`default_nettype none
module mfiw_cpu_model
   import mfiw_pkg::*;
(
   input wire logic mclk,
   input wire logic rstn,
   input wire mfiw_vec_t vec,
   input wire logic stackFull,
   input wire logic doReti,
   input wire logic doRet,
   input wire logic [3:0] ackWait,
   output var mfiw_cpu_t cpu,
   output var int pushCount
);
   logic ack = 1'b0;
   logic [3:0] waited = 4'h0;
   always_comb cpu = '{ack, doReti, doRet, stackFull};
   always @(posedge mclk)
   begin
      ack <= 1'b0;
      waited <= 4'h0;
      if (!rstn)
         pushCount <= 0;
      else
      begin
         if (vec.push)
            pushCount <= pushCount + 1;
         if (vec.req && !ack && waited == ackWait)
            ack <= 1'b1;
         else if (vec.req && !ack)
            waited <= waited + 4'h1;
      end
   end
endmodule : mfiw_cpu_model
`default_nettype wire

// >>> testbench/mfiw_top_test.sv
// self-checking bench for the grouped interrupt and wake-up block
`timescale 1ns/1ps
`default_nettype none
module mfiw_top_test
   import mfiw_pkg::*;
;
   typedef struct {int k; logic [4:0] f; logic [1:0] g;} mfiw_row_t;
   mfiw_row_t rows [6] = '{'{0, 5'h01, 2'h1}, '{1, 5'h01, 2'h1}, '{2, 5'h02, 2'h2},
      '{3, 5'h04, 2'h2}, '{4, 5'h08, 2'h2}, '{5, 5'h10, 2'h2}};
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic [5:0] src = 6'h00;
   logic lvEn = 1'b0;
   logic [1:0] enA = 2'h0;
   logic [1:0] grpEn = 2'h0;
   logic [4:0] swSet = 5'h00;
   logic [4:0] swClr = 5'h00;
   logic geSet = 1'b0;
   logic geClr = 1'b0;
   logic sleep = 1'b0;
   logic stackFull = 1'b0;
   logic doReti = 1'b0;
   logic doRet = 1'b0;
   logic [3:0] ackWait = 4'h0;
   mfiw_cpu_t cpu;
   mfiw_vec_t vec;
   logic lvFlag, ge, wake;
   logic [1:0] flagA, flagP, grpFlag;
   wire [4:0] flags = {flagP[1], flagA[1], flagP[0], flagA[0], lvFlag};
   int pushes;
   int wakes = 0;
   int w0;
   int checks = 0;
   int fails = 0;
   mfiw_top i_dut (.mclk(mclk), .rstn(rstn), .lowSupply(src[0]),
      .voltage_detect_input_pin(src[1]), .tmMatchA({src[4], src[2]}),
      .tmMatchP({src[5], src[3]}), .low_voltage_irq_enable(lvEn), .tmEnableA(enA),
      .tmEnableP(enA), .grouped_irq_enable(grpEn), .srcFlagSet(swSet), .srcFlagClr(swClr),
      .globalEnableSet(geSet), .globalEnableClr(geClr), .sleepMode(sleep), .cpu(cpu),
      .low_voltage_request_flag(lvFlag), .tmFlagA(flagA), .tmFlagP(flagP),
      .grouped_irq_request_flag(grpFlag), .global_irq_enable(ge), .vec(vec), .wake(wake));
   mfiw_cpu_model i_cpu (.mclk(mclk), .rstn(rstn), .vec(vec), .stackFull(stackFull),
      .doReti(doReti), .doRet(doRet), .ackWait(ackWait), .cpu(cpu), .pushCount(pushes));
   always #5 mclk = ~mclk;
   always @(posedge mclk)
      if (wake === 1'b1)
         wakes <= wakes + 1;
   task automatic cyc(int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : cyc
   task automatic check(logic [7:0] seen, logic [7:0] exp);
      checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic end_of_test();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : end_of_test
   initial
   begin
      cyc(6);
      rstn = 1'b1;
      cyc(1);
      check(8'({ge, wake, flags}), 8'h00);
      check(8'(grpFlag), 8'h00);
      sleep = 1'b1;
      foreach (rows[i])
      begin
         swClr = 5'h1F;
         cyc(1);
         swClr = 5'h00;
         w0 = wakes;
         src = 6'h01 << rows[i].k;
         cyc(1);
         src = 6'h00;
         cyc(5);
         check(8'(flags), 8'(rows[i].f));
         check(8'(grpFlag & rows[i].g), 8'(rows[i].g));
         check(8'(wakes != w0), 8'h01);
      end
      sleep = 1'b0;
      swSet = 5'h01;
      cyc(1);
      swSet = 5'h00;
      cyc(3);
      sleep = 1'b1;
      w0 = wakes;
      src = 6'h01;
      cyc(6);
      check(8'(wakes - w0), 8'h00);
      src = 6'h04;
      swClr = 5'h1E;
      cyc(1);
      src = 6'h00;
      swClr = 5'h00;
      cyc(10);
      check(8'(flags), 8'h03);
      sleep = 1'b0;
      enA = 2'h1;
      grpEn = 2'h2;
      stackFull = 1'b1;
      geSet = 1'b1;
      cyc(1);
      geSet = 1'b0;
      cyc(6);
      check(8'(vec.req), 8'h00);
      stackFull = 1'b0;
      ackWait = 4'h3;
      cyc(12);
      check(8'({ge, grpFlag, flags}), 8'h23);
      check(8'(pushes), 8'h01);
      doRet = 1'b1;
      cyc(1);
      doRet = 1'b0;
      cyc(2);
      check(8'(ge), 8'h00);
      doReti = 1'b1;
      cyc(1);
      doReti = 1'b0;
      cyc(4);
      check(8'(ge), 8'h01);
      check(8'(pushes), 8'h01);
      geClr = 1'b1;
      cyc(1);
      geClr = 1'b0;
      lvEn = 1'b1;
      grpEn = 2'h3;
      ackWait = 4'h0;
      cyc(4);
      check(8'({ge, vec.req}), 8'h00);
      geSet = 1'b1;
      cyc(1);
      geSet = 1'b0;
      cyc(12);
      check(8'({ge, grpFlag, flags}), 8'h03);
      check(8'(pushes), 8'h02);
      rstn = 1'b0;
      cyc(2);
      rstn = 1'b1;
      cyc(1);
      check(8'({ge, wake, flags}), 8'h00);
      check(8'({vec, grpFlag}), 8'h00);
      end_of_test();
   end
   initial
   begin
      #20000;
      fails++;
      end_of_test();
   end
endmodule : mfiw_top_test
`default_nettype wire
